// ### edge_event_detect.sv
// per-source edge detection gated by rising and falling enable masks
module edge_event_detect (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [4:0] sources,
	input wire logic [4:0] riseEnable,
	input wire logic [4:0] fallEnable,
	output logic [4:0] events
);
	logic [4:0] prevSources;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prevSources <= 5'h00;
		end else begin
			prevSources <= sources;
		end
	end

	always_comb begin
		events = (sources & ~prevSources & riseEnable)
			| (~sources & prevSources & fallEnable);
	end

	a_rise_reported: assert property (@(posedge sys_clk) disable iff (rst)
		(sources & ~prevSources & riseEnable) != 5'h00 |-> events != 5'h00)
		else $error("enabled rising edge not reported");
	a_fall_reported: assert property (@(posedge sys_clk) disable iff (rst)
		(~sources & prevSources & fallEnable) != 5'h00 |-> events != 5'h00)
		else $error("enabled falling edge not reported");
endmodule

// ### link_model.sv
// link side model that drives the register port
module link_model (
	input wire logic sys_clk,
	output logic [7:0] regAddr,
	output logic [7:0] regWriteData,
	output logic regWrite,
	output logic regRead
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		regAddr = 8'h00;
		regWriteData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
	end

	// released lines go to the inverse so a held value is never trusted
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		regAddr <= ~a;
		regWriteData <= ~d;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		regAddr <= ~a;
	endtask
endmodule

// ### otg_event_enable_status.sv
// otg termination controls and edge-selective event reporting with register port
// How it works
// - termination bit 2 set connects the host pull-down on the minus line.
// - termination bit 1 set connects the host pull-down on the plus line.
// - termination bit 0 set enables the ident pull-up and sampling of ident.
// - enabled rising change of a source bit raises an event toward the link.
// - enabled falling change of a source bit raises an event toward the link.
// - both edge masks reset to 1fh, upper three bits zero.
// - rising mask bits 4..0 are ident, session end, session ok, bus power, detach.
// - falling mask uses the same bit positions as the rising mask.
// - rising mask reads at 0dh..0fh; write 0dh, set 0eh, clear 0fh.
// - falling mask reads at 10h..12h; write 10h, set 11h, clear 12h.
// - status at 13h shows live unlatched source values, read only.
// - status bit 4 follows the ident grounded detector.
// - status bits 3..0 follow session end, session ok, bus power, detach.
//
// Added by the designer: the strobed register port.
module otg_event_enable_status (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regReadData,
	input wire otg_event_pkg::event_sources_t sourcesIn,
	output otg_event_pkg::termination_t termination,
	output logic [4:0] eventNotify,
	output logic irq
);
	otg_event_pkg::access_kind_t riseKind;
	otg_event_pkg::access_kind_t fallKind;
	otg_event_pkg::access_kind_t termKind;
	logic [7:0] riseMask;
	logic [7:0] fallMask;
	logic [7:0] termReg;
	logic [4:0] sourcesNow;
	logic [4:0] events;
	logic [4:0] irqStatus;
	logic [4:0] irqMask;
	logic [7:0] next_readData;

	// decode one register family: write, set and clear addresses
	function automatic otg_event_pkg::access_kind_t decode_access(
		input logic [7:0] addr,
		input logic wr,
		input logic [7:0] wrAddr,
		input logic [7:0] setAddr,
		input logic [7:0] clrAddr
	);
		otg_event_pkg::access_kind_t k;
		k = otg_event_pkg::ACC_NONE;
		if (!wr) begin
			k = otg_event_pkg::ACC_NONE;
		end else if (addr == wrAddr) begin
			k = otg_event_pkg::ACC_WRITE;
		end else if (addr == setAddr) begin
			k = otg_event_pkg::ACC_SET;
		end else if (addr == clrAddr) begin
			k = otg_event_pkg::ACC_CLEAR;
		end
		return k;
	endfunction

	always_comb begin
		riseKind = decode_access(regAddr, regWrite, otg_event_pkg::ADDR_RISE_WR,
			otg_event_pkg::ADDR_RISE_SET, otg_event_pkg::ADDR_RISE_CLR);
		fallKind = decode_access(regAddr, regWrite, otg_event_pkg::ADDR_FALL_WR,
			otg_event_pkg::ADDR_FALL_SET, otg_event_pkg::ADDR_FALL_CLR);
		termKind = decode_access(regAddr, regWrite, otg_event_pkg::ADDR_TERM_WR,
			otg_event_pkg::ADDR_TERM_SET, otg_event_pkg::ADDR_TERM_CLR);
	end

	rws_register #(.RESET_VALUE(otg_event_pkg::EDGE_ENABLE_RESET)) riseReg (
		.sys_clk(sys_clk),
		.rst(rst),
		.kind(riseKind),
		.data(regWriteData),
		.value(riseMask)
	);

	rws_register #(.RESET_VALUE(otg_event_pkg::EDGE_ENABLE_RESET)) fallReg (
		.sys_clk(sys_clk),
		.rst(rst),
		.kind(fallKind),
		.data(regWriteData),
		.value(fallMask)
	);

	rws_register #(.RESET_VALUE(otg_event_pkg::TERM_RESET)) termCtrl (
		.sys_clk(sys_clk),
		.rst(rst),
		.kind(termKind),
		.data(regWriteData),
		.value(termReg)
	);

	// struct order puts ident at bit 4 down to detach at bit 0
	assign sourcesNow = sourcesIn;

	// mask bit n gates source bit n for both edges
	edge_event_detect edges (
		.sys_clk(sys_clk),
		.rst(rst),
		.sources(sourcesNow),
		.riseEnable(riseMask[4:0]),
		.fallEnable(fallMask[4:0]),
		.events(events)
	);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			// pull-downs come up on and the ident sampler off, matching the register reset
			termination <= otg_event_pkg::termination_t'(otg_event_pkg::TERM_RESET[2:0]);
		end else begin
			termination.minusLinePulldownEn <= termReg[otg_event_pkg::BIT_MINUS_PULLDOWN];
			termination.plusLinePulldownEn <= termReg[otg_event_pkg::BIT_PLUS_PULLDOWN];
			termination.identLineSamplerEn <= termReg[otg_event_pkg::BIT_IDENT_SAMPLER];
		end
	end

	// one-cycle notify toward the link-side command generator
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			eventNotify <= 5'h00;
		end else begin
			eventNotify <= events;
		end
	end

	// sticky status: a new event wins over a write-one clear in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irqStatus <= 5'h00;
		end else if (regWrite && regAddr == otg_event_pkg::ADDR_IRQ_STATUS) begin
			irqStatus <= (irqStatus & ~regWriteData[4:0]) | events;
		end else begin
			irqStatus <= irqStatus | events;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irqMask <= otg_event_pkg::IRQ_MASK_RESET[4:0];
		end else if (regWrite && regAddr == otg_event_pkg::ADDR_IRQ_MASK) begin
			irqMask <= regWriteData[4:0];
		end
	end

	// registered level, so it trails the status bit by one cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStatus & irqMask);
		end
	end

	always_comb begin
		next_readData = 8'h00;
		if (regAddr >= otg_event_pkg::ADDR_RISE_WR && regAddr <= otg_event_pkg::ADDR_RISE_CLR) begin
			next_readData = riseMask;
		end else if (regAddr >= otg_event_pkg::ADDR_FALL_WR && regAddr <= otg_event_pkg::ADDR_FALL_CLR) begin
			next_readData = fallMask;
		end else if (regAddr == otg_event_pkg::ADDR_SOURCE_STATUS) begin
			// reserved upper bits read zero
			next_readData = {3'h0, sourcesNow};
		end else if (regAddr >= otg_event_pkg::ADDR_TERM_WR && regAddr <= otg_event_pkg::ADDR_TERM_CLR) begin
			next_readData = termReg;
		end else if (regAddr == otg_event_pkg::ADDR_IRQ_STATUS) begin
			next_readData = {3'h0, irqStatus};
		end else if (regAddr == otg_event_pkg::ADDR_IRQ_MASK) begin
			next_readData = {3'h0, irqMask};
		end
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			regReadData <= 8'h00;
		end else if (regRead) begin
			regReadData <= next_readData;
		end else begin
			regReadData <= 8'h00;
		end
	end

	a_mask_reset_value: assert property (@(posedge sys_clk)
		$fell(rst) |-> riseMask == 8'h1f && fallMask == 8'h1f)
		else $error("edge masks not at reset value");
	a_status_read_live: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == 8'h13 |=> regReadData == {3'h0, $past(sourcesIn)})
		else $error("status read not live source value");
	a_rise_read_alias: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr >= 8'h0d && regAddr <= 8'h0f |=> regReadData == $past(riseMask))
		else $error("rising mask read wrong");
	a_fall_read_alias: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr >= 8'h10 && regAddr <= 8'h12 |=> regReadData == $past(fallMask))
		else $error("falling mask read wrong");
	a_rise_notify_path: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(sourcesIn.identGrounded) && riseMask[4] |=> eventNotify[4])
		else $error("ident rise not notified");
	a_fall_notify_path: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(sourcesIn.hostDetach) && fallMask[0] |=> eventNotify[0])
		else $error("detach fall not notified");
	a_disabled_quiet: assert property (@(posedge sys_clk) disable iff (rst)
		$changed(sourcesIn.sessionOk) && !riseMask[2] && !fallMask[2] |=> !eventNotify[2])
		else $error("disabled edge notified");
	a_pulldown_follow: assert property (@(posedge sys_clk) disable iff (rst)
		##1 termination.minusLinePulldownEn == $past(termReg[2])
			&& termination.plusLinePulldownEn == $past(termReg[1]))
		else $error("pull-down control not following register");
	a_sampler_follow: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == 8'h0b && regWriteData[0] |=> ##1 termination.identLineSamplerEn)
		else $error("ident sampler not enabled by set");
endmodule

// ### otg_event_enable_status_tb.sv
// self-checking bench for the otg event enable and status block
module otg_event_enable_status_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic rdPend = 1'b0;
	logic [7:0] regAddr, regWriteData, regReadData, base;
	logic regWrite, regRead, irq;
	logic [4:0] eventNotify, riseM, fallM;
	logic [31:0] r;
	otg_event_pkg::event_sources_t sourcesIn;
	otg_event_pkg::termination_t termination;
	logic [7:0] rdQ[$];
	logic [4:0] evQ[$];
	int error_cnt = 0;
	int n_compared = 0;
	int seed = 32'hdf0dd9b8;

	always #2 sys_clk = ~sys_clk;

	link_model link (.sys_clk(sys_clk), .regAddr(regAddr), .regWriteData(regWriteData),
		.regWrite(regWrite), .regRead(regRead));

	otg_event_enable_status dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
		.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
		.regReadData(regReadData), .sourcesIn(sourcesIn), .termination(termination),
		.eventNotify(eventNotify), .irq(irq));

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		rdQ.push_back(e);
		link.rd(a);
	endtask

	// the expected event is noted when the source change is launched
	task automatic setSrc(input logic [4:0] n);
		logic [4:0] e;
		@(posedge sys_clk);
		e = (riseM & n & ~sourcesIn) | (fallM & sourcesIn & ~n);
		if (e != 5'h00) begin
			evQ.push_back(e);
		end
		sourcesIn <= n;
	endtask

	always @(posedge sys_clk) begin
		rdPend <= regRead;
	end

	always @(negedge sys_clk) begin
		if (rdPend) begin
			check("readData", regReadData, rdQ.pop_front());
		end else if (!rst) begin
			check("readIdle", regReadData, 8'h00);
		end
		if (eventNotify !== 5'h00) begin
			if (evQ.size() == 0) begin
				check("event", {3'b000, eventNotify}, 8'h00);
			end else begin
				check("event", {3'b000, eventNotify}, {3'b000, evQ.pop_front()});
			end
		end
	end

	initial begin
		sourcesIn = '0;
		riseM = 5'h1f;
		fallM = 5'h1f;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		check("termReset", {5'b00000, termination}, 8'h06);
		for (int i = 0; i < 6; i++) begin
			rdx(8'h0d + 8'(i), 8'h1f);
		end
		rdx(8'h21, 8'h00);
		for (int i = 0; i < 3; i++) begin
			base = (i == 0) ? 8'h0d : (i == 1) ? 8'h10 : 8'h0a;
			link.wr(base, 8'ha5);
			rdx(base, 8'ha5);
			link.wr(base + 8'h01, 8'h18);
			rdx(base + 8'h02, 8'hbd);
			link.wr(base + 8'h02, 8'h21);
			rdx(base + 8'h01, 8'h9c);
		end
		check("termination", {5'b00000, termination}, 8'h04);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			link.wr(8'h0a, r[7:0]);
			repeat (2) @(negedge sys_clk);
			check("termination", {5'b00000, termination}, {5'b00000, r[2:0]});
		end
		link.wr(8'h0a, 8'h00);
		link.wr(8'h0b, 8'h01);
		repeat (2) @(negedge sys_clk);
		check("sampler", {5'b00000, termination}, 8'h01);
		riseM = 5'h1c;
		fallM = 5'h1c;
		for (int i = 0; i < 48; i++) begin
			r = $random(seed);
			if (i % 8 == 7) begin
				link.wr(8'h0d, r[15:8]);
				link.wr(8'h10, r[23:16]);
				riseM = r[12:8];
				fallM = r[20:16];
			end
			setSrc(r[4:0]);
			rdx(8'h13, {3'b000, r[4:0]});
		end
		// the status byte is read only and unmapped places read zero
		link.wr(8'h13, 8'hff);
		rdx(8'h13, {3'b000, sourcesIn});
		rdx(8'h40, 8'h00);
		link.wr(8'h0d, 8'h1f);
		link.wr(8'h10, 8'h1f);
		riseM = 5'h1f;
		fallM = 5'h1f;
		link.wr(8'h21, 8'h00);
		link.wr(8'h20, 8'hff);
		setSrc(sourcesIn ^ 5'h10);
		repeat (3) @(negedge sys_clk);
		check("irqMasked", {7'b0000000, irq}, 8'h00);
		rdx(8'h20, 8'h10);
		link.wr(8'h21, 8'h10);
		repeat (2) @(negedge sys_clk);
		check("irqRaised", {7'b0000000, irq}, 8'h01);
		link.wr(8'h20, 8'h10);
		repeat (2) @(negedge sys_clk);
		check("irqCleared", {7'b0000000, irq}, 8'h00);
		for (int k = 0; k < 20 && (rdQ.size() + evQ.size()) != 0; k++) begin
			@(posedge sys_clk);
		end
		check("pending", 8'(rdQ.size() + evQ.size()), 8'h00);
		summarize();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		$display("mismatch watchdog expected done seen running");
		summarize();
	end
endmodule

// ### otg_event_pkg.sv
// shared constants and carriers for the otg event enable and status block
package otg_event_pkg;
	localparam logic [7:0] ADDR_RISE_WR = 8'h0d;
	localparam logic [7:0] ADDR_RISE_SET = 8'h0e;
	localparam logic [7:0] ADDR_RISE_CLR = 8'h0f;
	localparam logic [7:0] ADDR_FALL_WR = 8'h10;
	localparam logic [7:0] ADDR_FALL_SET = 8'h11;
	localparam logic [7:0] ADDR_FALL_CLR = 8'h12;
	localparam logic [7:0] ADDR_SOURCE_STATUS = 8'h13;
	localparam logic [7:0] ADDR_TERM_WR = 8'h0a;
	localparam logic [7:0] ADDR_TERM_SET = 8'h0b;
	localparam logic [7:0] ADDR_TERM_CLR = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
	localparam logic [7:0] EDGE_ENABLE_RESET = 8'h1f;
	localparam logic [7:0] TERM_RESET = 8'h06;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
	localparam logic [7:0] SOURCE_FIELD_MASK = 8'h1f;
	localparam int BIT_IDENT_GROUNDED = 4;
	localparam int BIT_SESSION_ENDED = 3;
	localparam int BIT_SESSION_OK = 2;
	localparam int BIT_BUS_POWER_OK = 1;
	localparam int BIT_HOST_DETACH = 0;
	localparam int BIT_MINUS_PULLDOWN = 2;
	localparam int BIT_PLUS_PULLDOWN = 1;
	localparam int BIT_IDENT_SAMPLER = 0;

	typedef enum logic [1:0] {
		ACC_NONE,
		ACC_WRITE,
		ACC_SET,
		ACC_CLEAR
	} access_kind_t;

	typedef struct packed {
		logic identGrounded;
		logic sessionEnded;
		logic sessionOk;
		logic busPowerOk;
		logic hostDetach;
	} event_sources_t;

	typedef struct packed {
		logic minusLinePulldownEn;
		logic plusLinePulldownEn;
		logic identLineSamplerEn;
	} termination_t;
endpackage

// ### rws_register.sv
// one byte register with write, set and clear accesses
module rws_register #(
	parameter logic [7:0] RESET_VALUE = 8'h00
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire otg_event_pkg::access_kind_t kind,
	input wire logic [7:0] data,
	output logic [7:0] value
);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			value <= RESET_VALUE;
		end else begin
			case (kind)
				otg_event_pkg::ACC_WRITE: value <= data;
				otg_event_pkg::ACC_SET: value <= value | data;
				otg_event_pkg::ACC_CLEAR: value <= value & ~data;
				default: value <= value;
			endcase
		end
	end

	a_set_keeps_bits: assert property (@(posedge sys_clk) disable iff (rst)
		kind == otg_event_pkg::ACC_SET |=> (value & $past(value)) == $past(value))
		else $error("set access lost a bit");
	a_clear_drops_bits: assert property (@(posedge sys_clk) disable iff (rst)
		kind == otg_event_pkg::ACC_CLEAR |=> (value & $past(data)) == 8'h00)
		else $error("clear access left a bit");
endmodule
